// ### verilog/stream_read_pkg.sv
// Shared constants, types and carriers for the streaming read decoder
package stream_read_pkg;
   // ----------------------------------------
   // Command block register addresses
   // ----------------------------------------
   localparam logic [2:0] TF_FEATURE = 3'h1;
   localparam logic [2:0] TF_COUNT = 3'h2;
   localparam logic [2:0] TF_LBA_LO = 3'h3;
   localparam logic [2:0] TF_LBA_MID = 3'h4;
   localparam logic [2:0] TF_LBA_HI = 3'h5;
   localparam logic [2:0] TF_COMMAND = 3'h7;
   localparam logic [7:0] CMD_READ_STREAM = 8'h2A;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int FLAG_PRIO = 7;
   localparam int FLAG_CONT = 6;
   localparam int FLAG_OOO = 5;
   localparam int FLAG_RESUME = 4;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_SE = 5;
   localparam int ST_ERR = 0;
   localparam int ER_CRC = 7;
   localparam int ER_UNC = 6;
   localparam int ER_IDNF = 4;
   localparam int ER_ABRT = 2;
   localparam int ER_COMPLETION_TIMEOUT_FLAG = 0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int MICROSECOND_NS = 1000;
   localparam logic [7:0] CYC_PER_US = 8'(MICROSECOND_NS / CLK_PERIOD_NS);
   localparam logic [39:0] MIN_LIMIT_US = 40'h00000003E8;
   localparam logic [16:0] MAX_SECTORS = 17'h10000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_XFER, S_FINISH} phase_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic hob;
      logic [2:0] addr;
      logic [7:0] wdata;
   } tf_req_type;
   typedef struct packed {
      logic [47:0] lba;
      logic [16:0] count;
      logic [2:0] sid;
      logic prio;
      logic cont;
      logic resume;
      logic ooo;
   } media_cmd_type;
   typedef struct packed {
      logic [15:0] data;
      logic last;
      logic crc;
      logic unc;
      logic idnf;
      logic abrt;
   } media_word_type;
endpackage : stream_read_pkg

// ### verilog/read_stream_param_decode.sv
// Streaming DMA read command decoder, time limit keeper and data buffer
// How it works
// - Priority flag asks media for fastest service; limit still enforced.
// - Continuous flag keeps reading through errors until full count delivered.
// - Continuous errors end with BSY 0, SE 1, ERR 0, error type logged.
// - Continuous timeout stops command, BSY 0, SE 1, ERR 0, timeout flag set.
// - With continuous flag, whole amount is attempted inside the limit despite bad data.
// - Resume flag means start at last error address; media may resume recovery.
// - Stream id from feature bits 2:0 selects that stream's stored settings.
// - Limit in microseconds is upper feature byte times identify words 99:98.
// - Zero upper feature byte uses stream's stored default limit.
// - Stored default zero or never configured means no limit.
// - Timing starts at command write, stops at completion interrupt.
// - Limit below built-in minimum is raised to the minimum.
// - Count is high byte and low byte; zero means 65,536 sectors.
// - Command code 2Ah selects the streaming read.
// - Error completion returns first unrecoverable error address in LBA registers.
`timescale 1ns/10ps
`default_nettype none
module read_stream_param_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command block register port
   input wire stream_read_pkg::tf_req_type tf_req,
   output logic [7:0] tf_rdata,
   output logic intrq,
   // Identify words 99:98 and stream configuration defaults
   input wire logic [31:0] limit_unit_us,
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_sid,
   input wire logic [39:0] cfg_default_us,
   // Media engine command
   output stream_read_pkg::media_cmd_type media_cmd,
   output logic media_cmd_valid,
   input wire logic media_cmd_ready,
   output logic media_abort,
   // Media data in
   input wire stream_read_pkg::media_word_type media_word,
   input wire logic media_valid,
   output logic media_ready,
   // Host DMA data out
   output logic [15:0] dma_data,
   output logic dma_valid,
   input wire logic dma_ready
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      stream_read_pkg::phase_type ph;
      logic [7:0] feat_cur;
      logic [7:0] feat_prev;
      logic [7:0] cnt_cur;
      logic [7:0] cnt_prev;
      logic [2:0][7:0] lba_cur;
      logic [2:0][7:0] lba_prev;
      stream_read_pkg::media_cmd_type cmd;
      logic cmd_valid;
      logic abort;
      logic [16:0] done;
      logic [39:0] limit;
      logic has_limit;
      logic [7:0] us_div;
      logic [39:0] us_cnt;
      logic bsy;
      logic se;
      logic err;
      logic [7:0] err_bits;
      logic got_err;
      logic [47:0] err_lba;
      logic intrq;
      logic [7:0] rdata;
      logic [7:0][39:0] def_us;
      logic [1:0][15:0] buf_q;
      logic [1:0] bcnt;
      logic in_ready;
      logic out_valid;
   } state_type;

   state_type s_ff;
   state_type nxt_s;

   // Picks one byte of a 48-bit address for the register read port
   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] idx);
      logic [47:0] sh;
      sh = a >> {idx, 3'h0};
      return sh[7:0];
   endfunction : addr_byte

   // Which of the three address byte registers an access selects
   function automatic logic [2:0] lba_slot(input logic [2:0] addr);
      return addr - stream_read_pkg::TF_LBA_LO;
   endfunction : lba_slot

   logic [47:0] cur_lba;
   logic [39:0] asked_us;
   logic [39:0] pick_us;
   logic push;
   logic pop;
   logic word_err;
   logic timed_out;

   always_comb begin
      cur_lba = {s_ff.lba_prev[2], s_ff.lba_prev[1], s_ff.lba_prev[0],
                 s_ff.lba_cur[2], s_ff.lba_cur[1], s_ff.lba_cur[0]};
      nxt_s = s_ff;
      nxt_s.abort = 1'b0;
      asked_us = 40'(s_ff.feat_prev * limit_unit_us);
      pick_us = asked_us;
      push = media_valid && s_ff.in_ready;
      pop = s_ff.out_valid && dma_ready;
      word_err = media_word.crc || media_word.unc || media_word.idnf || media_word.abrt;
      timed_out = s_ff.has_limit && (s_ff.us_cnt >= s_ff.limit);

      // ----------------------------------------
      // Stream configuration defaults
      // ----------------------------------------
      if (cfg_wr) begin
         nxt_s.def_us[cfg_sid] = cfg_default_us;
      end

      // ----------------------------------------
      // Register writes and command start
      // ----------------------------------------
      // Writes while busy are ignored so a running command keeps its inputs
      if (tf_req.wr && !s_ff.bsy) begin
         case (tf_req.addr)
            stream_read_pkg::TF_FEATURE: begin
               nxt_s.feat_prev = s_ff.feat_cur;
               nxt_s.feat_cur = tf_req.wdata;
            end
            stream_read_pkg::TF_COUNT: begin
               nxt_s.cnt_prev = s_ff.cnt_cur;
               nxt_s.cnt_cur = tf_req.wdata;
            end
            stream_read_pkg::TF_LBA_LO,
            stream_read_pkg::TF_LBA_MID,
            stream_read_pkg::TF_LBA_HI: begin
               nxt_s.lba_prev[lba_slot(tf_req.addr)] = s_ff.lba_cur[lba_slot(tf_req.addr)];
               nxt_s.lba_cur[lba_slot(tf_req.addr)] = tf_req.wdata;
            end
            stream_read_pkg::TF_COMMAND: begin
               nxt_s.bsy = 1'b1;
               nxt_s.intrq = 1'b0;
               nxt_s.se = 1'b0;
               nxt_s.err = 1'b0;
               nxt_s.err_bits = 8'h00;
               nxt_s.got_err = 1'b0;
               nxt_s.done = 17'h00000;
               nxt_s.us_div = 8'h00;
               nxt_s.us_cnt = 40'h0000000000;
               if (tf_req.wdata == stream_read_pkg::CMD_READ_STREAM) begin
                  nxt_s.cmd.lba = cur_lba;
                  nxt_s.cmd.sid = s_ff.feat_cur[2:0];
                  nxt_s.cmd.prio = s_ff.feat_cur[stream_read_pkg::FLAG_PRIO];
                  nxt_s.cmd.cont = s_ff.feat_cur[stream_read_pkg::FLAG_CONT];
                  nxt_s.cmd.ooo = s_ff.feat_cur[stream_read_pkg::FLAG_OOO];
                  nxt_s.cmd.resume = s_ff.feat_cur[stream_read_pkg::FLAG_RESUME];
                  if ({s_ff.cnt_prev, s_ff.cnt_cur} == 16'h0000) begin
                     nxt_s.cmd.count = stream_read_pkg::MAX_SECTORS;
                  end else begin
                     nxt_s.cmd.count = {1'b0, s_ff.cnt_prev, s_ff.cnt_cur};
                  end
                  if (s_ff.feat_prev == 8'h00) begin
                     pick_us = s_ff.def_us[s_ff.feat_cur[2:0]];
                  end
                  nxt_s.has_limit = (pick_us != 40'h0000000000);
                  if (pick_us < stream_read_pkg::MIN_LIMIT_US) begin
                     nxt_s.limit = stream_read_pkg::MIN_LIMIT_US;
                  end else begin
                     nxt_s.limit = pick_us;
                  end
                  nxt_s.cmd_valid = 1'b1;
                  nxt_s.ph = stream_read_pkg::S_ISSUE;
               end else begin
                  // Anything else is refused with an abort completion
                  nxt_s.err = 1'b1;
                  nxt_s.err_bits[stream_read_pkg::ER_ABRT] = 1'b1;
                  nxt_s.has_limit = 1'b0;
                  nxt_s.ph = stream_read_pkg::S_FINISH;
               end
            end
            default: begin
            end
         endcase
      end

      // ----------------------------------------
      // Microsecond timer
      // ----------------------------------------
      if (s_ff.bsy) begin
         if (s_ff.us_div == stream_read_pkg::CYC_PER_US - 8'h01) begin
            nxt_s.us_div = 8'h00;
            nxt_s.us_cnt = s_ff.us_cnt + 40'h0000000001;
         end else begin
            nxt_s.us_div = s_ff.us_div + 8'h01;
         end
      end

      // ----------------------------------------
      // Command sequence
      // ----------------------------------------
      case (s_ff.ph)
         stream_read_pkg::S_IDLE: begin
         end
         stream_read_pkg::S_ISSUE: begin
            if (timed_out) begin
               nxt_s.cmd_valid = 1'b0;
               nxt_s.abort = 1'b1;
               nxt_s.err_bits[stream_read_pkg::ER_COMPLETION_TIMEOUT_FLAG] = 1'b1;
               nxt_s.se = s_ff.cmd.cont;
               nxt_s.err = !s_ff.cmd.cont;
               nxt_s.ph = stream_read_pkg::S_FINISH;
            end else if (media_cmd_ready) begin
               nxt_s.cmd_valid = 1'b0;
               nxt_s.ph = stream_read_pkg::S_XFER;
            end
         end
         stream_read_pkg::S_XFER: begin
            if (push) begin
               if (word_err) begin
                  nxt_s.err_bits[stream_read_pkg::ER_CRC] = s_ff.err_bits[stream_read_pkg::ER_CRC]
                     | media_word.crc;
                  nxt_s.err_bits[stream_read_pkg::ER_UNC] = s_ff.err_bits[stream_read_pkg::ER_UNC]
                     | media_word.unc;
                  nxt_s.err_bits[stream_read_pkg::ER_IDNF] =
                     s_ff.err_bits[stream_read_pkg::ER_IDNF] | media_word.idnf;
                  nxt_s.err_bits[stream_read_pkg::ER_ABRT] =
                     s_ff.err_bits[stream_read_pkg::ER_ABRT] | media_word.abrt;
                  if (!s_ff.got_err) begin
                     nxt_s.got_err = 1'b1;
                     nxt_s.err_lba = s_ff.cmd.lba + 48'(s_ff.done);
                  end
               end
               if (word_err && !s_ff.cmd.cont) begin
                  nxt_s.err = 1'b1;
                  nxt_s.abort = 1'b1;
                  nxt_s.ph = stream_read_pkg::S_FINISH;
               end else if (media_word.last) begin
                  nxt_s.done = s_ff.done + 17'h00001;
                  if (s_ff.done + 17'h00001 == s_ff.cmd.count) begin
                     // SE settles at the final sector, so a bad sector anywhere counts
                     nxt_s.se = s_ff.cmd.cont && (s_ff.got_err || word_err);
                     nxt_s.ph = stream_read_pkg::S_FINISH;
                  end
               end
            end
            if (timed_out && nxt_s.ph == stream_read_pkg::S_XFER) begin
               nxt_s.abort = 1'b1;
               nxt_s.err_bits[stream_read_pkg::ER_COMPLETION_TIMEOUT_FLAG] = 1'b1;
               nxt_s.se = s_ff.cmd.cont;
               nxt_s.err = !s_ff.cmd.cont;
               nxt_s.ph = stream_read_pkg::S_FINISH;
            end
         end
         stream_read_pkg::S_FINISH: begin
            // Completion waits for the buffer to drain so no word is cut off
            if (s_ff.bcnt == 2'h0 && !(tf_req.wr && tf_req.addr == stream_read_pkg::TF_COMMAND)) begin
               nxt_s.bsy = 1'b0;
               nxt_s.intrq = 1'b1;
               nxt_s.ph = stream_read_pkg::S_IDLE;
            end
         end
         default: begin
            nxt_s.ph = stream_read_pkg::S_IDLE;
         end
      endcase

      // ----------------------------------------
      // Two-entry data buffer
      // ----------------------------------------
      if (pop) begin
         nxt_s.buf_q[0] = s_ff.buf_q[1];
      end
      if (push) begin
         nxt_s.buf_q[(pop ? s_ff.bcnt - 2'h1 : s_ff.bcnt) == 2'h0 ? 0 : 1] = media_word.data;
      end
      nxt_s.bcnt = s_ff.bcnt + {1'b0, push} - {1'b0, pop};
      nxt_s.out_valid = (nxt_s.bcnt != 2'h0);
      nxt_s.in_ready = (nxt_s.bcnt != 2'h2) && (nxt_s.ph == stream_read_pkg::S_XFER);

      // ----------------------------------------
      // Register reads
      // ----------------------------------------
      if (tf_req.rd) begin
         case (tf_req.addr)
            stream_read_pkg::TF_FEATURE: begin
               nxt_s.rdata = s_ff.err_bits;
            end
            stream_read_pkg::TF_COUNT: begin
               nxt_s.rdata = tf_req.hob ? s_ff.cnt_prev : s_ff.cnt_cur;
            end
            stream_read_pkg::TF_LBA_LO,
            stream_read_pkg::TF_LBA_MID,
            stream_read_pkg::TF_LBA_HI: begin
               // Error address replaces the command address after a sector error
               nxt_s.rdata = addr_byte(s_ff.got_err ? s_ff.err_lba : cur_lba,
                  lba_slot(tf_req.addr) + (tf_req.hob ? 3'h3 : 3'h0));
            end
            stream_read_pkg::TF_COMMAND: begin
               nxt_s.rdata = 8'h00;
               nxt_s.rdata[stream_read_pkg::ST_BSY] = s_ff.bsy;
               nxt_s.rdata[stream_read_pkg::ST_RDY] = !s_ff.bsy;
               nxt_s.rdata[stream_read_pkg::ST_SE] = s_ff.se;
               nxt_s.rdata[stream_read_pkg::ST_ERR] = s_ff.err;
               // Status read acknowledges the interrupt unless completion lands now
               if (!(nxt_s.intrq && !s_ff.intrq)) begin
                  nxt_s.intrq = 1'b0;
               end
            end
            default: begin
               nxt_s.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tf_rdata = s_ff.rdata;
   assign intrq = s_ff.intrq;
   assign media_cmd = s_ff.cmd;
   assign media_cmd_valid = s_ff.cmd_valid;
   assign media_abort = s_ff.abort;
   assign media_ready = s_ff.in_ready;
   assign dma_data = s_ff.buf_q[0];
   assign dma_valid = s_ff.out_valid;
endmodule : read_stream_param_decode
`default_nettype wire

// ### verification/rsp_asserts.sv
// Port assertions for the streaming read decoder
`timescale 1ns/10ps
`default_nettype none
module rsp_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire stream_read_pkg::tf_req_type tf_req,
   input wire logic intrq,
   // Media and host data
   input wire stream_read_pkg::media_cmd_type media_cmd,
   input wire logic media_cmd_valid,
   input wire logic media_cmd_ready,
   input wire logic media_abort,
   input wire logic media_ready,
   input wire logic [15:0] dma_data,
   input wire logic dma_valid,
   input wire logic dma_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic busy_ff, nxt_busy, cmd_wr, go, stat_rd, idle;
   logic [7:0] feat_ff, nxt_feat;
   // BSY drops in the same edge that raises the interrupt
   assign idle = !busy_ff || intrq;
   // Writes while busy are dropped by the block, so the shadows skip them too
   assign cmd_wr = tf_req.wr && tf_req.addr == stream_read_pkg::TF_COMMAND && idle;
   assign go = cmd_wr && tf_req.wdata == stream_read_pkg::CMD_READ_STREAM;
   assign stat_rd = tf_req.rd && tf_req.addr == stream_read_pkg::TF_COMMAND;
   always_comb begin
      nxt_busy = cmd_wr || (busy_ff && !intrq);
      nxt_feat = feat_ff;
      if (tf_req.wr && tf_req.addr == stream_read_pkg::TF_FEATURE && idle) begin
         nxt_feat = tf_req.wdata;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {busy_ff, feat_ff} <= 9'h000;
      end else begin
         {busy_ff, feat_ff} <= {nxt_busy, nxt_feat};
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_CMD_START: assert property (go |=> media_cmd_valid)
   else $error("stream command not passed on");
   AST_BAD_CODE: assert property (cmd_wr && !go |=> !media_cmd_valid ##[0:15] intrq)
   else $error("foreign command not refused");
   AST_CMD_HOLD: assert property (media_cmd_valid && !media_cmd_ready ##1 media_cmd_valid
      |-> $stable(media_cmd))
   else $error("media command moved while waiting");
   AST_FLAGS: assert property (media_cmd_valid |-> {media_cmd.prio, media_cmd.cont,
      media_cmd.ooo, media_cmd.resume, media_cmd.sid} == {feat_ff[7:4], feat_ff[2:0]})
   else $error("media flags differ from feature byte");
   AST_COUNT: assert property (media_cmd_valid |-> media_cmd.count != 17'h00000
      && media_cmd.count <= stream_read_pkg::MAX_SECTORS)
   else $error("sector count out of range");
   AST_ABORT_PULSE: assert property (media_abort |=> !media_abort)
   else $error("abort longer than one cycle");
   AST_DMA_HOLD: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data))
   else $error("host word lost under stall");
   AST_DONE_IDLE: assert property (intrq |-> !media_ready && !media_cmd_valid && !dma_valid)
   else $error("interrupt while still moving data");
   AST_INTRQ_HOLD: assert property (intrq && !stat_rd && !cmd_wr |=> intrq)
   else $error("interrupt dropped without status read");
   cover property (media_cmd_valid && media_cmd_ready);
   cover property (media_abort);
   cover property (dma_valid && !dma_ready);
endmodule : rsp_asserts
`default_nettype wire

// ### verification/media_model.sv
// Behavioural media engine answering the decoder's read commands
`timescale 1ns/10ps
`default_nettype none
module media_model #(
   parameter int WPS = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command handshake
   input wire stream_read_pkg::media_cmd_type media_cmd,
   input wire logic media_cmd_valid,
   output logic media_cmd_ready,
   input wire logic media_abort,
   // Word stream
   output stream_read_pkg::media_word_type media_word,
   output logic media_valid,
   input wire logic media_ready,
   // Scenario controls: stall holds words back, err_kind flags sector err_sec
   input wire logic stall,
   input wire logic [3:0] err_kind,
   input wire logic [31:0] err_sec
);
   int k, tot;
   logic act;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {media_cmd_ready, media_valid, act, media_word} <= '0;
         {k, tot} <= '0;
      end else begin
         media_cmd_ready <= media_cmd_valid && !media_cmd_ready && !act;
         if (media_cmd_valid && media_cmd_ready) begin
            {act, k, tot} <= {1'b1, 32'h0, WPS * int'(media_cmd.count)};
         end else if (media_abort || k >= tot) begin
            act <= 1'b0;
         end
         if (!media_valid || media_ready) begin
            if (act && !stall && k < tot && !media_abort) begin
               media_valid <= 1'b1;
               media_word <= {16'(k), k % WPS == WPS - 1, k / WPS == err_sec ? err_kind : 4'h0};
               k <= k + 1;
            end else begin
               // Released bus toggles so stale data never looks like a word
               media_valid <= 1'b0;
               media_word.data <= ~media_word.data;
            end
         end
         if (media_abort) begin
            media_valid <= 1'b0;
         end
      end
   end
endmodule : media_model
`default_nettype wire

// ### verification/tb_read_stream_param_decode.sv
// Self-checking bench for the streaming read decoder
`timescale 1ns/10ps
`default_nettype none
module tb_read_stream_param_decode;
   localparam logic [7:0] CMD = stream_read_pkg::CMD_READ_STREAM;
   localparam logic [2:0] A_FEAT = stream_read_pkg::TF_FEATURE;
   localparam logic [2:0] A_STAT = stream_read_pkg::TF_COMMAND;
   stream_read_pkg::tf_req_type tf_req;
   stream_read_pkg::media_cmd_type media_cmd;
   stream_read_pkg::media_word_type media_word;
   logic clk, rstn, intrq, cfg_wr, cmd_valid, cmd_ready, abort, m_valid, m_ready;
   logic dma_valid, dma_ready, stall;
   logic [7:0] tf_rdata;
   logic [31:0] unit_us, err_sec;
   logic [39:0] cfg_us;
   logic [15:0] dma_data;
   logic [3:0] err_kind;
   logic [2:0] cfg_sid;
   int bad_count = 0, cmp_count = 0;
   read_stream_param_decode read_stream_param_decode_inst (
      .clk(clk), .rstn(rstn), .tf_req(tf_req), .tf_rdata(tf_rdata), .intrq(intrq),
      .limit_unit_us(unit_us), .cfg_wr(cfg_wr), .cfg_sid(cfg_sid), .cfg_default_us(cfg_us),
      .media_cmd(media_cmd), .media_cmd_valid(cmd_valid), .media_cmd_ready(cmd_ready),
      .media_abort(abort), .media_word(media_word), .media_valid(m_valid),
      .media_ready(m_ready), .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready));
   media_model media_model_inst (
      .clk(clk), .rstn(rstn), .media_cmd(media_cmd), .media_cmd_valid(cmd_valid),
      .media_cmd_ready(cmd_ready), .media_abort(abort), .media_word(media_word),
      .media_valid(m_valid), .media_ready(m_ready), .stall(stall), .err_kind(err_kind),
      .err_sec(err_sec));
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) tf_req <= '{1'b1, 1'b0, 1'b0, a, d};
      @(posedge clk) tf_req <= '0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, input logic hob, output logic [7:0] d);
      @(posedge clk) tf_req <= '{1'b0, 1'b1, hob, a, 8'h00};
      @(posedge clk) tf_req <= '0;
      @(negedge clk) d = tf_rdata;
   endtask : reg_rd
   // Loads each register high byte first, then fires the command code
   task automatic start(input logic [7:0] feat, fprev, input logic [15:0] cnt,
      input logic [47:0] lba, input logic [7:0] code);
      reg_wr(A_FEAT, fprev);
      reg_wr(A_FEAT, feat);
      reg_wr(stream_read_pkg::TF_COUNT, cnt[15:8]);
      reg_wr(stream_read_pkg::TF_COUNT, cnt[7:0]);
      for (int i = 0; i < 3; i++) begin
         reg_wr(3'(stream_read_pkg::TF_LBA_LO + i), lba[24 + 8 * i +: 8]);
         reg_wr(3'(stream_read_pkg::TF_LBA_LO + i), lba[8 * i +: 8]);
      end
      reg_wr(A_STAT, code);
      if (code == CMD) begin
         for (int i = 0; i < 50 && cmd_valid !== 1'b1; i++) @(negedge clk);
         check(media_cmd, {lba, (cnt == 16'h0000 ? 17'h10000 : {1'b0, cnt}), feat[2:0],
            feat[7], feat[6], feat[4], feat[5]});
      end
   endtask : start
   // Sinks host words while receiver and media both stall now and then
   task automatic drain(input int hold, output int k);
      k = 0;
      for (int i = 0; i < 5000; i++) begin
         @(negedge clk);
         if (intrq === 1'b1) break;
         // A word shown with ready high here leaves at the coming edge
         if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
            check(dma_data, 16'(k));
            k++;
         end
         @(posedge clk);
         dma_ready <= (i % 3 != 2);
         stall <= (i < hold) || (i % 5 == 4);
      end
   endtask : drain
   task automatic ending(input logic [2:0] st, input logic [7:0] er, mask);
      logic [7:0] d;
      check(intrq, 1'b1);
      reg_rd(A_STAT, 1'b0, d);
      check({d[7], d[5], d[0]}, st);
      check(intrq, 1'b0);
      reg_rd(A_FEAT, 1'b0, d);
      check(d & mask, er);
   endtask : ending
   task automatic t_plain();
      int k;
      start(8'hA2, 8'h00, 16'h0003, 48'h123456789ABC, CMD);
      drain(0, k);
      check(k, 6);
      ending(3'b000, 8'h00, 8'hFF);
      $display("plain read done");
   endtask : t_plain
   task automatic t_cont();
      int k;
      for (int i = 0; i < 4; i++) begin
         err_kind = 4'h8 >> i;
         start(i == 1 ? 8'h55 : 8'h45, 8'h00, 16'h0002, 48'h000000000100, CMD);
         drain(0, k);
         check(k, 4);
         ending(3'b010, {i == 0, i == 1, 1'b0, i == 2, 1'b0, i == 3, 2'b00}, 8'hFF);
      end
      $display("continuous errors done");
   endtask : t_cont
   task automatic t_abort();
      int k;
      logic [7:0] d;
      err_kind = 4'h4;
      start(8'h01, 8'h00, 16'h0000, 48'h00A0B0C0D0FF, CMD);
      drain(0, k);
      ending(3'b001, 8'h40, 8'h40);
      for (int i = 0; i < 6; i++) begin
         reg_rd(3'(stream_read_pkg::TF_LBA_LO + i % 3), i > 2, d);
         check(d, 48'h00A0B0C0D100 >> (8 * i) & 8'hFF);
      end
      err_kind = 4'h0;
      $display("abort and address done");
   endtask : t_abort
   task automatic t_limit();
      int k;
      @(posedge clk) {cfg_wr, cfg_sid, cfg_us, unit_us} <= {1'b1, 3'h3, 40'h1, 32'h1};
      @(posedge clk) cfg_wr <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         start(i ? 8'h43 : 8'h40, i ? 8'h00 : 8'h01, 16'h0001, 48'h0, CMD);
         drain(400, k);
         check(k, 2);
         ending(3'b000, 8'h00, 8'hFF);
      end
      $display("time limit floor done");
   endtask : t_limit
   task automatic t_bad();
      start(8'h00, 8'h00, 16'h0001, 48'h0, 8'h20);
      for (int i = 0; i < 20 && intrq !== 1'b1; i++) @(negedge clk);
      check(cmd_valid, 1'b0);
      ending(3'b001, 8'h04, 8'hFF);
      $display("foreign command done");
   endtask : t_bad
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {rstn, cfg_wr, dma_ready, stall, cfg_sid, err_kind} = 11'h000;
      {tf_req, unit_us, cfg_us} = '0;
      err_sec = 32'h1;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      check({intrq, cmd_valid, abort, dma_valid, m_ready}, 5'h00);
      t_plain();
      t_cont();
      t_abort();
      t_limit();
      t_bad();
      tally_and_finish();
   end
   // Whole run needs under two thousand cycles; this cuts a hang short
   initial begin
      #(4 * 60000);
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_read_stream_param_decode
bind read_stream_param_decode rsp_asserts rsp_asserts_inst (.clk(clk), .rstn(rstn),
   .tf_req(tf_req), .intrq(intrq), .media_cmd(media_cmd), .media_cmd_valid(media_cmd_valid),
   .media_cmd_ready(media_cmd_ready), .media_abort(media_abort), .media_ready(media_ready),
   .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready));
`default_nettype wire
